// *** fpt_map.svh ***
`ifndef FPT_MAP_SVH
`define FPT_MAP_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FPT_CLK_HZ 250000000
`define FPT_PWM_HZ 156000
`define FPT_PWM_CYC (`FPT_CLK_HZ / `FPT_PWM_HZ)
`define FPT_WIN_S 1
`define FPT_WIN_CYC (`FPT_WIN_S * `FPT_CLK_HZ)
`define FPT_DUTY_MAX 100
`define FPT_FAULT_WINS 5
`define FPT_SEC_PER_MIN 60

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define FPT_OFF_CTRL 8'h00
`define FPT_OFF_DUTY 8'h04
`define FPT_OFF_FANCFG 8'h08
`define FPT_OFF_LIMIT 8'h0C
`define FPT_OFF_SPEED 8'h10
`define FPT_OFF_FSTAT 8'h14
`define FPT_OFF_ISTS 8'h18
`define FPT_OFF_IMASK 8'h1C

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define FPT_CTRL_EN_BIT 0
`define FPT_CFG_PPR_LSB 0
`define FPT_CFG_PRESENT_BIT 4
`define FPT_FSTAT_FAULT_BIT 0
`define FPT_FSTAT_BELOW_BIT 1
`define FPT_INT_FAULT_BIT 0
`define FPT_INT_MEAS_BIT 1
`define FPT_RST_DUTY 7'h00
`define FPT_RST_PPR 2'h0
`define FPT_RST_LIMIT 16'h0000

`endif

// *** fpt_pkg.sv ***
package fpt_pkg;

  typedef enum logic [2:0] {
    FPT_OK = 3'h1,
    FPT_SLOW = 3'h2,
    FPT_FAULT = 3'h4
  } fpt_flt_e;

  typedef struct packed {
    logic done;
    logic [15:0] rpm;
  } fpt_meas_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] high;
    logic out;
  } fpt_pwm_s;

  typedef struct packed {
    logic [1:0] sync;
    logic last;
    logic [31:0] win;
    logic [15:0] trans;
    fpt_meas_s meas;
  } fpt_tach_s;

  typedef struct packed {
    logic en;
    logic [6:0] duty;
    logic [1:0] ppr;
    logic present;
    logic [15:0] limit;
    logic [15:0] speed;
    logic below;
    logic [2:0] fcnt;
    fpt_flt_e flt;
    logic [1:0] ists;
    logic [1:0] mask;
    logic [31:0] prdata;
  } fpt_reg_s;

endpackage

// *** fpt_pwm.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "fpt_map.svh"

module fpt_pwm #(
  parameter int PERIOD_CYC = `FPT_PWM_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic en,
  input wire logic [6:0] duty,
  // pin
  output logic fan_pwm
);

  fpt_pkg::fpt_pwm_s s_q;
  fpt_pkg::fpt_pwm_s s_d;

  function automatic logic [15:0] high_cyc(input logic [6:0] d);
    logic [23:0] p;
    p = 24'(d) * 24'(PERIOD_CYC);
    return 16'(p / 24'(`FPT_DUTY_MAX));
  endfunction

  // duty only taken at period start so a duty write never makes a runt pulse
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == 16'(PERIOD_CYC - 1)) begin
      s_d.cnt = 16'h0000;
      s_d.high = high_cyc(duty);
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    s_d.out = en && (s_d.cnt < s_d.high);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fan_pwm = s_q.out;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_pwm_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cnt == 16'(PERIOD_CYC - 1) |=> s_q.cnt == 16'h0000)
    else $error("pwm period counter did not wrap");
  a_pwm_full: assert property (@(posedge pclk) disable iff (!presetn)
    en && duty == 7'h64 && s_q.cnt == 16'(PERIOD_CYC - 1) |=> fan_pwm)
    else $error("full duty not high");
  a_pwm_zero: assert property (@(posedge pclk) disable iff (!presetn)
    duty == 7'h00 && s_q.cnt == 16'(PERIOD_CYC - 1) |=> !fan_pwm)
    else $error("zero duty not low");

endmodule

`default_nettype wire

// *** fpt_tach.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "fpt_map.svh"

module fpt_tach #(
  parameter int WIN_CYC = `FPT_WIN_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and setup
  input wire logic tach_input,
  input wire logic [1:0] ppr,
  // result
  output fpt_pkg::fpt_meas_s meas
);

  fpt_pkg::fpt_tach_s s_q;
  fpt_pkg::fpt_tach_s s_d;
  logic edge_seen;

  // truncates: speeds below one revolution per window read as zero
  function automatic logic [15:0] to_rpm(input logic [15:0] tr, input logic [1:0] pp);
    logic [15:0] pulses;
    logic [15:0] revs;
    logic [21:0] m;
    pulses = tr >> 1;
    case (pp)
      2'h0: revs = pulses;
      2'h1: revs = pulses >> 1;
      2'h2: revs = pulses / 16'h0003;
      2'h3: revs = pulses >> 2;
      default: revs = pulses;
    endcase
    m = 22'(revs) * 22'(`FPT_SEC_PER_MIN);
    return (m > 22'h00FFFF) ? 16'hFFFF : m[15:0];
  endfunction

  assign edge_seen = s_q.sync[1] ^ s_q.last;

  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], tach_input};
    s_d.last = s_q.sync[1];
    s_d.meas.done = 1'b0;
    if (s_q.win == 32'(WIN_CYC - 1)) begin
      s_d.win = 32'h0000_0000;
      s_d.meas.rpm = to_rpm(s_q.trans, ppr);
      s_d.meas.done = 1'b1;
      s_d.trans = {15'h0000, edge_seen};
    end else begin
      s_d.win = s_q.win + 32'h0000_0001;
      if (edge_seen && s_q.trans != 16'hFFFF) begin
        s_d.trans = s_q.trans + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign meas = s_q.meas;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_win_restart: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.meas.done |-> s_q.trans <= 16'h0001 && s_q.win == 32'h0000_0000)
    else $error("window did not restart count");

endmodule

`default_nettype wire

// *** fpt_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "fpt_map.svh"

module fpt_top #(
  parameter int WIN_CYC = `FPT_WIN_CYC,
  parameter int PWM_CYC = `FPT_PWM_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fan pins
  input wire logic tach_input,
  output logic fan_pwm,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fpt_pkg::fpt_reg_s s_q;
  fpt_pkg::fpt_reg_s s_d;
  fpt_pkg::fpt_meas_s meas;
  logic setup;
  logic access;
  logic wr;
  logic rd_ists;
  logic below_now;
  logic [2:0] fcnt_next;

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `FPT_OFF_CTRL, `FPT_OFF_DUTY, `FPT_OFF_FANCFG, `FPT_OFF_LIMIT,
      `FPT_OFF_SPEED, `FPT_OFF_FSTAT, `FPT_OFF_ISTS, `FPT_OFF_IMASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a, input fpt_pkg::fpt_reg_s r);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `FPT_OFF_CTRL: w[`FPT_CTRL_EN_BIT] = r.en;
      `FPT_OFF_DUTY: w[6:0] = r.duty;
      `FPT_OFF_FANCFG: begin
        w[`FPT_CFG_PPR_LSB +: 2] = r.ppr;
        w[`FPT_CFG_PRESENT_BIT] = r.present;
      end
      `FPT_OFF_LIMIT: w[15:0] = r.limit;
      `FPT_OFF_SPEED: w[15:0] = r.speed;
      `FPT_OFF_FSTAT: begin
        w[`FPT_FSTAT_FAULT_BIT] = (r.flt == fpt_pkg::FPT_FAULT);
        w[`FPT_FSTAT_BELOW_BIT] = r.below;
      end
      `FPT_OFF_ISTS: w[1:0] = r.ists;
      `FPT_OFF_IMASK: w[1:0] = r.mask;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && addr_ok(paddr);
  assign rd_ists = access && !pwrite && paddr == `FPT_OFF_ISTS;
  assign below_now = meas.rpm < s_q.limit;
  assign fcnt_next = (s_q.fcnt == 3'(`FPT_FAULT_WINS)) ? s_q.fcnt : s_q.fcnt + 3'h1;

  always_comb begin
    s_d = s_q;
    // read data is captured in setup so it is a flop during access
    if (setup) begin
      s_d.prdata = rd_word(paddr, s_q);
    end
    if (wr) begin
      case (paddr)
        `FPT_OFF_CTRL: s_d.en = pwdata[`FPT_CTRL_EN_BIT];
        `FPT_OFF_DUTY: begin
          if (pwdata[7:0] > 8'(`FPT_DUTY_MAX)) begin
            s_d.duty = 7'(`FPT_DUTY_MAX);
          end else begin
            s_d.duty = pwdata[6:0];
          end
        end
        `FPT_OFF_FANCFG: begin
          s_d.ppr = pwdata[`FPT_CFG_PPR_LSB +: 2];
          s_d.present = pwdata[`FPT_CFG_PRESENT_BIT];
        end
        `FPT_OFF_LIMIT: s_d.limit = pwdata[15:0];
        `FPT_OFF_IMASK: s_d.mask = pwdata[1:0];
        default: s_d.mask = s_q.mask;
      endcase
    end
    // only bits actually returned are cleared, so a late event survives
    if (rd_ists) begin
      s_d.ists = s_q.ists & ~s_q.prdata[1:0];
    end
    if (meas.done) begin
      s_d.speed = meas.rpm;
      s_d.below = s_q.present && below_now;
      s_d.ists[`FPT_INT_MEAS_BIT] = 1'b1;
      if (!s_q.present || !below_now) begin
        s_d.fcnt = 3'h0;
        s_d.flt = fpt_pkg::FPT_OK;
      end else begin
        s_d.fcnt = fcnt_next;
        case (s_q.flt)
          fpt_pkg::FPT_OK, fpt_pkg::FPT_SLOW: begin
            if (fcnt_next == 3'(`FPT_FAULT_WINS)) begin
              s_d.flt = fpt_pkg::FPT_FAULT;
              s_d.ists[`FPT_INT_FAULT_BIT] = 1'b1;
            end else begin
              s_d.flt = fpt_pkg::FPT_SLOW;
            end
          end
          fpt_pkg::FPT_FAULT: s_d.flt = fpt_pkg::FPT_FAULT;
          default: s_d.flt = fpt_pkg::FPT_OK;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.duty <= `FPT_RST_DUTY;
      s_q.ppr <= `FPT_RST_PPR;
      s_q.limit <= `FPT_RST_LIMIT;
      s_q.flt <= fpt_pkg::FPT_OK;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // zero wait states: every access completes in its first cycle
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok(paddr);
  assign prdata = s_q.prdata;
  assign irq = |(s_q.ists & s_q.mask);

  // ------------------------------------------------------------
  // fan pwm and tach
  // ------------------------------------------------------------
  fpt_pwm #(
    .PERIOD_CYC(PWM_CYC)
  ) u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .en(s_q.en),
    .duty(s_q.duty),
    .fan_pwm(fan_pwm)
  );

  fpt_tach #(
    .WIN_CYC(WIN_CYC)
  ) u_tach (
    .pclk(pclk),
    .presetn(presetn),
    .tach_input(tach_input),
    .ppr(s_q.ppr),
    .meas(meas)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_pwm_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.en |=> !fan_pwm)
    else $error("pwm active while disabled");

  a_duty_range: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `FPT_OFF_DUTY |=> s_q.duty <= 7'h64 &&
      (s_q.duty == 7'h64 || s_q.duty == $past(pwdata[6:0])))
    else $error("duty write not taken or not clamped");

  a_speed_update: assert property (@(posedge pclk) disable iff (!presetn)
    meas.done |=> s_q.speed == $past(meas.rpm))
    else $error("speed not updated from window");

  a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `FPT_OFF_FANCFG |=>
      s_q.present == $past(pwdata[4]) && s_q.ppr == $past(pwdata[1:0]))
    else $error("fan setup write lost");

  a_fault_five: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.flt == fpt_pkg::FPT_FAULT) |-> $past(s_q.fcnt) == 3'h4)
    else $error("fault raised before five slow windows");

  a_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)
    meas.done && !below_now |=> s_q.flt == fpt_pkg::FPT_OK && s_q.fcnt == 3'h0)
    else $error("fast window did not clear fault");

  a_limit_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `FPT_OFF_LIMIT |=> s_q.limit == $past(pwdata[15:0]))
    else $error("limit write lost");

  a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `FPT_OFF_FSTAT |=>
      prdata[0] == ($past(s_q.flt) == fpt_pkg::FPT_FAULT))
    else $error("status byte misreports fault");

  a_irq_meas: assert property (@(posedge pclk) disable iff (!presetn)
    meas.done && s_q.mask[1] |=> irq ##1 (irq || $past(rd_ists)))
    else $error("measure interrupt missing");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    access && !addr_ok(paddr) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `FPT_OFF_CTRL |=> s_q.en == $past(pwdata[`FPT_CTRL_EN_BIT]))
    else $error("enable write lost");

  a_duty_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == `FPT_OFF_DUTY) |=> $stable(s_q.duty))
    else $error("duty changed without a write");

  a_duty_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `FPT_OFF_DUTY |=> prdata[6:0] == $past(s_q.duty))
    else $error("duty readback wrong");

  a_meas_flag: assert property (@(posedge pclk) disable iff (!presetn)
    meas.done |=> s_q.ists[`FPT_INT_MEAS_BIT])
    else $error("window end not flagged");

  a_speed_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !meas.done |=> $stable(s_q.speed))
    else $error("speed changed inside a window");

  a_speed_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `FPT_OFF_SPEED |=> prdata[15:0] == $past(s_q.speed))
    else $error("speed readback wrong");

  a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == `FPT_OFF_FANCFG) |=> $stable(s_q.ppr) && $stable(s_q.present))
    else $error("fan setup changed without a write");

  a_cfg_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `FPT_OFF_FANCFG |=>
      prdata[`FPT_CFG_PRESENT_BIT] == $past(s_q.present))
    else $error("fan present readback wrong");

  a_absent_clear: assert property (@(posedge pclk) disable iff (!presetn)
    meas.done && !s_q.present |=> s_q.flt == fpt_pkg::FPT_OK && !s_q.below)
    else $error("absent fan left a fault");

  a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.flt == fpt_pkg::FPT_FAULT) |-> s_q.ists[`FPT_INT_FAULT_BIT])
    else $error("fault event not flagged");

  a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.flt == fpt_pkg::FPT_FAULT && !meas.done |=> s_q.flt == fpt_pkg::FPT_FAULT)
    else $error("fault dropped inside a window");

  a_fault_count: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.flt == fpt_pkg::FPT_FAULT |-> s_q.fcnt == 3'(`FPT_FAULT_WINS))
    else $error("fault without full slow count");

  a_fcnt_cap: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.fcnt <= 3'(`FPT_FAULT_WINS))
    else $error("slow window count overran");

  a_slow_below: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.flt != fpt_pkg::FPT_OK |-> s_q.below)
    else $error("slow state without below flag");

  a_limit_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == `FPT_OFF_LIMIT) |=> $stable(s_q.limit))
    else $error("limit changed without a write");

  a_limit_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `FPT_OFF_LIMIT |=> prdata[15:0] == $past(s_q.limit))
    else $error("limit readback wrong");

  a_below_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `FPT_OFF_FSTAT |=>
      prdata[`FPT_FSTAT_BELOW_BIT] == $past(s_q.below))
    else $error("below flag readback wrong");

  a_ists_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ists && !meas.done |=> (s_q.ists & $past(s_q.prdata[1:0])) == 2'h0)
    else $error("status read did not clear returned bits");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `FPT_OFF_IMASK |=> s_q.mask == $past(pwdata[1:0]))
    else $error("mask write lost");

  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !addr_ok(paddr) |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    access && addr_ok(paddr) |-> !pslverr)
    else $error("mapped access flagged as error");

  c_slverr: cover property (@(posedge pclk) disable iff (!presetn)
    access && pslverr);

  c_fault: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.flt == fpt_pkg::FPT_FAULT));
  c_full_duty: cover property (@(posedge pclk) disable iff (!presetn)
    s_q.en && s_q.duty == 7'h64 ##1 fan_pwm);
  c_irq_clear: cover property (@(posedge pclk) disable iff (!presetn)
    irq ##1 rd_ists ##1 !irq);
  c_meas: cover property (@(posedge pclk) disable iff (!presetn)
    meas.done && meas.rpm != 16'h0000);

endmodule

`default_nettype wire

// *** fpt_fan.sv ***
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// fan model: tach line toggles every gap cycles while spinning
// ------------------------------------------------------------
module fpt_fan (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // speed control from the bench
  input wire logic run,
  input wire logic [7:0] gap,
  // tach pin
  output logic tach_input
);
  logic [7:0] cnt_q;

  // a stopped fan leaves the tach line where it was, as a real rotor does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      tach_input <= 1'h0;
    end else if (run) begin
      if (cnt_q >= gap - 8'h01) begin
        cnt_q <= 8'h00;
        tach_input <= ~tach_input;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// *** test_fan_pwm_tach_controller.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_fan_pwm_tach_controller;
  // short window and period keep the run brief
  localparam int WIN = 200;
  localparam int PER = 20;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } fpt_row_s;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tach_input;
  logic fan_pwm;
  logic irq;
  logic run = 1'h0;
  logic [7:0] gap = 8'h19;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] rv;
  logic re;
  int hc;
  fpt_row_s rows [10];
  int dl [5] = '{0, 7, 25, 50, 100};
  int tg [5] = '{25, 25, 10, 20, 50};
  int tp [5] = '{0, 1, 3, 2, 0};

  always #2 pclk = ~pclk;

  fpt_top #(.WIN_CYC(WIN), .PWM_CYC(PER)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tach_input(tach_input), .fan_pwm(fan_pwm), .irq(irq)
  );

  fpt_fan fan_u (
    .pclk(pclk), .presetn(presetn), .run(run), .gap(gap), .tach_input(tach_input)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    chk("pready", 32'h1, {31'h0, pready});
    rv = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), x, rv);
  endtask

  // irq with only the measurement bit unmasked marks each window end
  task win;
    int n;
    n = 0;
    @(negedge pclk);
    while (irq !== 1'h1 && n < 2 * WIN) begin
      n++;
      @(negedge pclk);
    end
    chk("window irq", 32'h1, {31'h0, irq});
    repeat (3) @(posedge pclk);
  endtask

  task hi(input int n);
    hc = 0;
    repeat (n) begin
      @(negedge pclk);
      if (fan_pwm === 1'h1) hc++;
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #200000;
    err_total++;
    test_done();
  end

  initial begin
    rows = '{{8'h04, 32'h32, 32'h32, 1'h0}, {8'h04, 32'h64, 32'h64, 1'h0},
      {8'h04, 32'h65, 32'h64, 1'h0}, {8'h04, 32'hFF, 32'h64, 1'h0},
      {8'h10, 32'hFFFF, 32'h0, 1'h0}, {8'h14, 32'h3, 32'h0, 1'h0},
      {8'h0C, 32'h1ABCD, 32'hABCD, 1'h0}, {8'h08, 32'h13, 32'h13, 1'h0},
      {8'h00, 32'h1, 32'h1, 1'h0}, {8'h20, 32'h5A, 32'h0, 1'h1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    chk("fan_pwm", 32'h0, {31'h0, fan_pwm});
    chk("irq", 32'h0, {31'h0, irq});
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d);
      chk("write err", 32'(rows[i].e), {31'h0, re});
      rd(rows[i].a, rows[i].x);
      chk("read err", 32'(rows[i].e), {31'h0, re});
    end
    $display("test registers done");
    foreach (dl[i]) begin
      apb(1'h1, 8'h04, 32'(dl[i]));
      repeat (3 * PER) @(posedge pclk);
      hi(5 * PER);
      chk("pwm high", 32'((dl[i] * PER / 100) * 5), 32'(hc));
    end
    apb(1'h1, 8'h00, 32'h0);
    repeat (2 * PER) @(posedge pclk);
    hi(5 * PER);
    chk("pwm off", 32'h0, 32'(hc));
    $display("test pwm done");
    run <= 1'h1;
    foreach (tg[i]) begin
      gap <= 8'(tg[i]);
      apb(1'h1, 8'h08, 32'(tp[i]));
      repeat (2 * WIN + 20) @(posedge pclk);
      rd(8'h10, 32'(((WIN / tg[i]) / 2) / (tp[i] + 1) * 60));
    end
    $display("test tach done");
    // 240 rpm against a 300 rpm limit: below every window
    gap <= 8'h19;
    apb(1'h1, 8'h1C, 32'h2);
    repeat (2 * WIN) @(posedge pclk);
    apb(1'h0, 8'h18, 32'h0);
    win();
    rd(8'h18, 32'h2);
    apb(1'h1, 8'h0C, 32'h12C);
    apb(1'h1, 8'h08, 32'h10);
    for (int k = 1; k <= 5; k++) begin
      win();
      rd(8'h18, (k == 5) ? 32'h3 : 32'h2);
      rd(8'h14, (k == 5) ? 32'h3 : 32'h2);
    end
    apb(1'h1, 8'h0C, 32'h64);
    win();
    rd(8'h18, 32'h2);
    rd(8'h14, 32'h0);
    apb(1'h1, 8'h1C, 32'h1);
    apb(1'h1, 8'h0C, 32'h12C);
    repeat (6 * WIN + 20) @(posedge pclk);
    @(negedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'h1, 8'h1C, 32'h0);
    @(negedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'h1, 8'h1C, 32'h1);
    rd(8'h18, 32'h3);
    @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test fault done");
    apb(1'h1, 8'h00, 32'h1);
    @(posedge pclk);
    presetn <= 1'h0;
    @(negedge pclk);
    chk("fan_pwm rst", 32'h0, {31'h0, fan_pwm});
    chk("irq rst", 32'h0, {31'h0, irq});
    @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    $display("test second reset done");
    test_done();
  end
endmodule

`default_nettype wire
